// ---- hdl/pll_cfg_pkg.sv ----
// Package for the dual-PLL divider configuration register block.
// Assumes an AXI4-Lite master with 32-bit data and word-aligned byte addresses.
package pll_cfg_pkg;

  // ==========================================================================
  // Register indices (printed offsets are not word aligned) and widths
  localparam int          ADDR_W          = 12;
  localparam logic [7:0]  IDX_A_REF_DIV   = 8'h34;
  localparam logic [7:0]  IDX_A_M_DIV     = 8'h35;
  localparam logic [7:0]  IDX_B_REF_DIV   = 8'h36;
  localparam logic [7:0]  IDX_B_M_DIV     = 8'h37;
  localparam logic [7:0]  IDX_A_CTRL0     = 8'h38;
  localparam logic [7:0]  IDX_STATUS      = 8'h39;

  // ==========================================================================
  // Field layout
  localparam int REF_W      = 3;
  localparam int M_W        = 5;
  localparam int POST_W     = 3;
  localparam int POST_LSB   = 2;
  localparam int RESYNC_BIT = 1;
  localparam int PDN_BIT    = 0;
  localparam int RATIO_W    = 6;

  // ==========================================================================
  // Reset values
  localparam logic [REF_W-1:0]  REF_RST    = 3'h0;
  localparam logic [M_W-1:0]    M_RST      = 5'h00;
  localparam logic [POST_W-1:0] POST_RST   = 3'h7;
  localparam logic              RESYNC_RST = 1'b1;
  localparam logic              PDN_RST    = 1'b0;

  // ==========================================================================
  // Calibration timing
  localparam int CAL_TIME_NS = 1000;
  localparam int CLK_NS      = 40;
  localparam int CAL_CYCLES  = (CAL_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAL_CNT_W   = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CAL_IDLE  = 2'b00,
    CAL_RESET = 2'b01,
    CAL_RUN   = 2'b10,
    CAL_DONE  = 2'b11
  } cal_state_t;

  typedef struct packed {
    logic [REF_W-1:0]  a_ref;
    logic [M_W-1:0]    a_m;
    logic [REF_W-1:0]  b_ref;
    logic [M_W-1:0]    b_m;
    logic [POST_W-1:0] a_post;
    logic              a_resync;
    logic              a_pdn;
  } pll_cfg_t;

  typedef struct packed {
    logic               bypass;
    logic [RATIO_W-1:0] ratio;
  } div_sel_t;

endpackage : pll_cfg_pkg

// ---- hdl/pll_divider_config_regs.sv ----
// Divider and control registers for two PLLs, with AXI4-Lite slave access.
// Assumes a synchronous active-high reset and a resync event synchronous to CLK_IN.
//
// Contract
// - First PLL reference code 0 bypasses, code k divides by k+1.
// - First PLL M code 0 bypasses, code k divides by k+1.
// - Second PLL reference code 0 bypasses, code k divides by k+1.
// - Second PLL M code 0 bypasses, code k divides by k+1.
// - First PLL post codes 0 and 1 divide by 2, codes 2 to 7 by code plus one.
// - With resync enabled a resync event resynchronises first-PLL channels, else it is ignored.
// - Power-down 0 enables the PLL, 1 disables it and resets calibration.
// - With power-down 0 at hardware reset the PLL is enabled and calibrated automatically.
`timescale 1ns/1ps
module pll_divider_config_regs
  import pll_cfg_pkg::*;
(
  input  wire logic              CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire logic              S_AXI_AWVALID_IN,
  output logic                   S_AXI_AWREADY_OUT,
  input  wire logic [31:0]       S_AXI_WDATA_IN,
  input  wire logic [3:0]        S_AXI_WSTRB_IN,
  input  wire logic              S_AXI_WVALID_IN,
  output logic                   S_AXI_WREADY_OUT,
  output logic [1:0]             S_AXI_BRESP_OUT,
  output logic                   S_AXI_BVALID_OUT,
  input  wire logic              S_AXI_BREADY_IN,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire logic              S_AXI_ARVALID_IN,
  output logic                   S_AXI_ARREADY_OUT,
  output logic [31:0]            S_AXI_RDATA_OUT,
  output logic [1:0]             S_AXI_RRESP_OUT,
  output logic                   S_AXI_RVALID_OUT,
  input  wire logic              S_AXI_RREADY_IN,
  input  wire logic              RESYNC_EVENT_IN,
  output logic                   PLL_A_REF_BYPASS_OUT,
  output logic [RATIO_W-1:0]     PLL_A_REF_RATIO_OUT,
  output logic                   PLL_A_M_BYPASS_OUT,
  output logic [RATIO_W-1:0]     PLL_A_M_RATIO_OUT,
  output logic                   PLL_B_REF_BYPASS_OUT,
  output logic [RATIO_W-1:0]     PLL_B_REF_RATIO_OUT,
  output logic                   PLL_B_M_BYPASS_OUT,
  output logic [RATIO_W-1:0]     PLL_B_M_RATIO_OUT,
  output logic [RATIO_W-1:0]     PLL_A_POST_RATIO_OUT,
  output logic                   PLL_A_RESYNC_OUT,
  output logic                   PLL_A_ENABLE_OUT,
  output logic                   PLL_A_CAL_RESET_OUT,
  output logic                   PLL_A_CAL_RUN_OUT,
  output logic                   PLL_A_CAL_DONE_OUT
);

  // ==========================================================================
  // Decoding helpers
  function automatic div_sel_t decode_div(input logic [M_W-1:0] code);
    div_sel_t d;
    d.bypass = (code == 5'h00);
    d.ratio  = d.bypass ? 6'h01 : ({1'b0, code} + 6'h01);
    return d;
  endfunction : decode_div

  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
    return addr[9:2];
  endfunction : word_index

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [7:0] i;
    i = word_index(addr);
    return (addr[ADDR_W-1:10] == '0) && (i >= IDX_A_REF_DIV) && (i <= IDX_STATUS);
  endfunction : is_mapped

  pll_cfg_t   cfg;
  cal_state_t cal_state;
  cal_state_t next_cal_state;
  logic [CAL_CNT_W-1:0] cal_cnt;
  logic       pdn_prev;
  logic       rst_seen;
  logic       aw_held;
  logic       w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic [31:0] rd_word;

  // ==========================================================================
  // Write channel: address and data taken independently, response after both
  assign do_write = aw_held && w_held && !S_AXI_BVALID_OUT;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      aw_held           <= 1'b0;
      aw_addr           <= '0;
      S_AXI_AWREADY_OUT <= 1'b0;
    end else begin
      S_AXI_AWREADY_OUT <= !aw_held && !S_AXI_AWREADY_OUT && !S_AXI_BVALID_OUT;
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_held           <= 1'b1;
        aw_addr           <= S_AXI_AWADDR_IN;
        S_AXI_AWREADY_OUT <= 1'b0;
      end
      // Held address is freed only when the response is launched
      if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Write data acceptance
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      w_held           <= 1'b0;
      w_data           <= 32'h0000_0000;
      w_strb           <= 4'h0;
      S_AXI_WREADY_OUT <= 1'b0;
    end else begin
      S_AXI_WREADY_OUT <= !w_held && !S_AXI_WREADY_OUT && !S_AXI_BVALID_OUT;
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_held           <= 1'b1;
        w_data           <= S_AXI_WDATA_IN;
        w_strb           <= S_AXI_WSTRB_IN;
        S_AXI_WREADY_OUT <= 1'b0;
      end
      if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Write response
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= RESP_OKAY;
    end else begin
      if (do_write) begin
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Configuration registers; only byte lane 0 carries fields
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      cfg.a_ref    <= REF_RST;
      cfg.a_m      <= M_RST;
      cfg.b_ref    <= REF_RST;
      cfg.b_m      <= M_RST;
      cfg.a_post   <= POST_RST;
      cfg.a_resync <= RESYNC_RST;
      cfg.a_pdn    <= PDN_RST;
    end else if (do_write && w_strb[0] && is_mapped(aw_addr)) begin
      // Reserved bits of the write data are dropped
      unique case (word_index(aw_addr))
        IDX_A_REF_DIV: cfg.a_ref <= w_data[REF_W-1:0];
        IDX_A_M_DIV:   cfg.a_m   <= w_data[M_W-1:0];
        IDX_B_REF_DIV: cfg.b_ref <= w_data[REF_W-1:0];
        IDX_B_M_DIV:   cfg.b_m   <= w_data[M_W-1:0];
        IDX_A_CTRL0: begin
          cfg.a_post   <= w_data[POST_LSB +: POST_W];
          cfg.a_resync <= w_data[RESYNC_BIT];
          cfg.a_pdn    <= w_data[PDN_BIT];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Read channel
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (word_index(S_AXI_ARADDR_IN))
      IDX_A_REF_DIV: rd_word[REF_W-1:0] = cfg.a_ref;
      IDX_A_M_DIV:   rd_word[M_W-1:0]   = cfg.a_m;
      IDX_B_REF_DIV: rd_word[REF_W-1:0] = cfg.b_ref;
      IDX_B_M_DIV:   rd_word[M_W-1:0]   = cfg.b_m;
      IDX_A_CTRL0: begin
        rd_word[POST_LSB +: POST_W] = cfg.a_post;
        rd_word[RESYNC_BIT]         = cfg.a_resync;
        rd_word[PDN_BIT]            = cfg.a_pdn;
      end
      IDX_STATUS: rd_word[1:0] = cal_state;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // One-cycle ready pulse; never raised while a read answer is pending
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      S_AXI_ARREADY_OUT <= 1'b0;
    end else begin
      S_AXI_ARREADY_OUT <= !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT && S_AXI_ARVALID_IN;
    end
  end

  // ==========================================================================
  // Read response
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      S_AXI_RVALID_OUT  <= 1'b0;
      S_AXI_RDATA_OUT   <= 32'h0000_0000;
      S_AXI_RRESP_OUT   <= RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
        S_AXI_RVALID_OUT  <= 1'b1;
        S_AXI_RDATA_OUT   <= is_mapped(S_AXI_ARADDR_IN) ? rd_word : 32'h0000_0000;
        S_AXI_RRESP_OUT   <= is_mapped(S_AXI_ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
        S_AXI_RVALID_OUT <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Calibration sequencer
  // rst_seen marks the first cycle after reset release, so a cleared
  // power-down bit at reset kicks off calibration without software.
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rst_seen <= 1'b1;
      pdn_prev <= PDN_RST;
    end else begin
      rst_seen <= 1'b0;
      pdn_prev <= cfg.a_pdn;
    end
  end

  always_comb begin
    next_cal_state = cal_state;
    if (cfg.a_pdn) begin
      next_cal_state = CAL_RESET;
    end else begin
      unique case (cal_state)
        CAL_IDLE:  if (rst_seen) next_cal_state = CAL_RUN;
        CAL_RESET: if (pdn_prev) next_cal_state = CAL_RUN;
        CAL_RUN:   if (cal_cnt == CAL_CNT_W'(CAL_CYCLES - 1)) next_cal_state = CAL_DONE;
        CAL_DONE:  next_cal_state = CAL_DONE;
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      cal_state <= CAL_IDLE;
      cal_cnt   <= '0;
    end else begin
      cal_state <= next_cal_state;
      cal_cnt   <= (cal_state == CAL_RUN) ? cal_cnt + 1'b1 : '0;
    end
  end

  // ==========================================================================
  // Core-facing outputs, all registered
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      PLL_A_REF_BYPASS_OUT <= 1'b1;
      PLL_A_REF_RATIO_OUT  <= 6'h01;
      PLL_A_M_BYPASS_OUT   <= 1'b1;
      PLL_A_M_RATIO_OUT    <= 6'h01;
      PLL_B_REF_BYPASS_OUT <= 1'b1;
      PLL_B_REF_RATIO_OUT  <= 6'h01;
      PLL_B_M_BYPASS_OUT   <= 1'b1;
      PLL_B_M_RATIO_OUT    <= 6'h01;
    end else begin
      {PLL_A_REF_BYPASS_OUT, PLL_A_REF_RATIO_OUT} <= decode_div({2'b00, cfg.a_ref});
      {PLL_A_M_BYPASS_OUT, PLL_A_M_RATIO_OUT}     <= decode_div(cfg.a_m);
      {PLL_B_REF_BYPASS_OUT, PLL_B_REF_RATIO_OUT} <= decode_div({2'b00, cfg.b_ref});
      {PLL_B_M_BYPASS_OUT, PLL_B_M_RATIO_OUT}     <= decode_div(cfg.b_m);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      PLL_A_POST_RATIO_OUT <= 6'h08;
    end else begin
      PLL_A_POST_RATIO_OUT <= (cfg.a_post < 3'h2) ? 6'h02 : ({3'b000, cfg.a_post} + 6'h01);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      PLL_A_RESYNC_OUT <= 1'b0;
    end else begin
      // Event is dropped, not deferred, while resync is disabled
      PLL_A_RESYNC_OUT <= RESYNC_EVENT_IN && cfg.a_resync;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      PLL_A_ENABLE_OUT     <= 1'b0;
      PLL_A_CAL_RESET_OUT  <= 1'b0;
      PLL_A_CAL_RUN_OUT    <= 1'b0;
      PLL_A_CAL_DONE_OUT   <= 1'b0;
    end else begin
      PLL_A_ENABLE_OUT     <= !cfg.a_pdn;
      PLL_A_CAL_RESET_OUT  <= (next_cal_state == CAL_RESET);
      PLL_A_CAL_RUN_OUT    <= (next_cal_state == CAL_RUN);
      PLL_A_CAL_DONE_OUT   <= (next_cal_state == CAL_DONE);
    end
  end

endmodule : pll_divider_config_regs

// ---- dv/pll_cfg_properties.sv ----
// Assertions on the divider register block outputs.
// Assumes binding into pll_divider_config_regs; sees its ports only.
`timescale 1ns/1ps
module pll_cfg_properties
  import pll_cfg_pkg::*;
(
  input wire logic               CLK_IN,
  input wire logic               RST_IN,
  input wire logic               RESYNC_EVENT_IN,
  input wire logic               S_AXI_RVALID_OUT,
  input wire logic [31:0]        S_AXI_RDATA_OUT,
  input wire logic               PLL_A_REF_BYPASS_OUT,
  input wire logic               PLL_A_M_BYPASS_OUT,
  input wire logic               PLL_B_REF_BYPASS_OUT,
  input wire logic               PLL_B_M_BYPASS_OUT,
  input wire logic [RATIO_W-1:0] PLL_A_REF_RATIO_OUT,
  input wire logic [RATIO_W-1:0] PLL_A_M_RATIO_OUT,
  input wire logic [RATIO_W-1:0] PLL_B_REF_RATIO_OUT,
  input wire logic [RATIO_W-1:0] PLL_B_M_RATIO_OUT,
  input wire logic [RATIO_W-1:0] PLL_A_POST_RATIO_OUT,
  input wire logic               PLL_A_RESYNC_OUT,
  input wire logic               PLL_A_ENABLE_OUT,
  input wire logic               PLL_A_CAL_RESET_OUT,
  input wire logic               PLL_A_CAL_RUN_OUT,
  input wire logic               PLL_A_CAL_DONE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // ==========================================================================
  // Divider decode
  property p_a_ref; PLL_A_REF_BYPASS_OUT ? PLL_A_REF_RATIO_OUT == 6'h01 : PLL_A_REF_RATIO_OUT inside {[2:8]}; endproperty
  a_a_ref: assert property (p_a_ref) else $error("ref A ratio out of range");
  property p_a_m; PLL_A_M_BYPASS_OUT ? PLL_A_M_RATIO_OUT == 6'h01 : PLL_A_M_RATIO_OUT inside {[2:32]}; endproperty
  a_a_m: assert property (p_a_m) else $error("M A ratio out of range");
  property p_b_ref; PLL_B_REF_BYPASS_OUT ? PLL_B_REF_RATIO_OUT == 6'h01 : PLL_B_REF_RATIO_OUT inside {[2:8]}; endproperty
  a_b_ref: assert property (p_b_ref) else $error("ref B ratio out of range");
  property p_b_m; PLL_B_M_BYPASS_OUT ? PLL_B_M_RATIO_OUT == 6'h01 : PLL_B_M_RATIO_OUT inside {[2:32]}; endproperty
  a_b_m: assert property (p_b_m) else $error("M B ratio out of range");
  property p_post; PLL_A_POST_RATIO_OUT inside {[2:8]}; endproperty
  a_post: assert property (p_post) else $error("post ratio out of range");
  // ==========================================================================
  // Resync, power-down, calibration and reserved read bits
  property p_resync; PLL_A_RESYNC_OUT |-> $past(RESYNC_EVENT_IN); endproperty
  a_resync: assert property (p_resync) else $error("resync without event");
  property p_pdn; !$past(RST_IN) |-> (PLL_A_ENABLE_OUT != PLL_A_CAL_RESET_OUT)
    && (!PLL_A_CAL_RESET_OUT || !(PLL_A_CAL_RUN_OUT || PLL_A_CAL_DONE_OUT)); endproperty
  a_pdn: assert property (p_pdn) else $error("power-down state inconsistent");
  sequence s_release; $fell(RST_IN); endsequence
  sequence s_auto_cal; PLL_A_ENABLE_OUT && PLL_A_CAL_RUN_OUT; endsequence
  property p_auto_cal; s_release |=> s_auto_cal; endproperty
  a_auto_cal: assert property (p_auto_cal) else $error("no auto calibration after reset");
  property p_restart; $rose(PLL_A_ENABLE_OUT) |-> ##[0:1] PLL_A_CAL_RUN_OUT [*8]; endproperty
  a_restart: assert property (p_restart) else $error("no calibration on enable");
  property p_cal_done; $fell(PLL_A_CAL_RUN_OUT) && !PLL_A_CAL_RESET_OUT |-> PLL_A_CAL_DONE_OUT; endproperty
  a_cal_done: assert property (p_cal_done) else $error("calibration ended without done");
  property p_rsvd; S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h000000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("upper read bits not zero");
endmodule : pll_cfg_properties

bind pll_divider_config_regs pll_cfg_properties u_props (.*);

// ---- dv/pll_divider_config_regs_bench.sv ----
// Self-checking bench for the divider registers over AXI4-Lite.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
module pll_divider_config_regs_bench import pll_cfg_pkg::*; ;
  logic CLK_IN = 1'b0, RST_IN = 1'b1, RESYNC_EVENT_IN = 1'b0;
  logic S_AXI_AWVALID_IN = 1'b0, S_AXI_WVALID_IN = 1'b0, S_AXI_BREADY_IN = 1'b0;
  logic S_AXI_ARVALID_IN = 1'b0, S_AXI_RREADY_IN = 1'b0;
  logic [ADDR_W-1:0] S_AXI_AWADDR_IN = '0, S_AXI_ARADDR_IN = '0;
  logic [31:0] S_AXI_WDATA_IN = '0, S_AXI_RDATA_OUT, rd;
  logic [3:0] S_AXI_WSTRB_IN = '0;
  logic S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT;
  logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, rsp;
  logic PLL_A_REF_BYPASS_OUT, PLL_A_M_BYPASS_OUT, PLL_B_REF_BYPASS_OUT, PLL_B_M_BYPASS_OUT;
  logic [RATIO_W-1:0] PLL_A_REF_RATIO_OUT, PLL_A_M_RATIO_OUT, PLL_B_REF_RATIO_OUT, PLL_B_M_RATIO_OUT;
  logic [RATIO_W-1:0] PLL_A_POST_RATIO_OUT;
  logic PLL_A_RESYNC_OUT, PLL_A_ENABLE_OUT, PLL_A_CAL_RESET_OUT, PLL_A_CAL_RUN_OUT, PLL_A_CAL_DONE_OUT;
  int err_count = 0, n_tests = 0;
  always #20 CLK_IN = ~CLK_IN;
  pll_divider_config_regs dut (.*);
  // ==========================================================================
  // Checking and bus tasks
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic hang(input int n);
    if (n > 200) begin
      err_count++;
      $display("FAIL %0t wait timed out", $time);
      end_of_test();
    end
  endtask : hang
  function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction : ba
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n = 0;
    S_AXI_AWADDR_IN <= a;
    S_AXI_WDATA_IN <= d;
    S_AXI_WSTRB_IN <= s;
    S_AXI_AWVALID_IN <= 1'b1;
    S_AXI_WVALID_IN <= 1'b1;
    S_AXI_BREADY_IN <= 1'b1;
    do begin
      @(posedge CLK_IN);
      n++;
      hang(n);
      if (S_AXI_AWREADY_OUT === 1'b1) S_AXI_AWVALID_IN <= 1'b0;
      if (S_AXI_WREADY_OUT === 1'b1) S_AXI_WVALID_IN <= 1'b0;
    end while (S_AXI_BVALID_OUT !== 1'b1);
    rsp = S_AXI_BRESP_OUT;
    S_AXI_BREADY_IN <= 1'b0;
    @(posedge CLK_IN);
    chk(rsp, er, "bresp");
  endtask : wr
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    S_AXI_ARADDR_IN <= a;
    S_AXI_ARVALID_IN <= 1'b1;
    S_AXI_RREADY_IN <= 1'b1;
    do begin
      @(posedge CLK_IN);
      n++;
      hang(n);
      if (S_AXI_ARREADY_OUT === 1'b1) S_AXI_ARVALID_IN <= 1'b0;
    end while (S_AXI_RVALID_OUT !== 1'b1);
    rd = S_AXI_RDATA_OUT;
    rsp = S_AXI_RRESP_OUT;
    S_AXI_RREADY_IN <= 1'b0;
    @(posedge CLK_IN);
    chk(rd, ed, "rdata");
    chk(rsp, er, "rresp");
  endtask : rdc
  // Waits for calibration to finish, then checks how long it took
  task automatic cal_wait(input int lo);
    int n = 0;
    while (PLL_A_CAL_DONE_OUT !== 1'b1) begin
      @(posedge CLK_IN);
      #1;
      n++;
      hang(n);
    end
    chk(n >= lo && n <= CAL_CYCLES + 2, 1, "cal time");
  endtask : cal_wait
  function automatic logic [6:0] div_out(input int i);
    case (i)
      0: return {PLL_A_REF_BYPASS_OUT, PLL_A_REF_RATIO_OUT};
      1: return {PLL_A_M_BYPASS_OUT, PLL_A_M_RATIO_OUT};
      2: return {PLL_B_REF_BYPASS_OUT, PLL_B_REF_RATIO_OUT};
      default: return {PLL_B_M_BYPASS_OUT, PLL_B_M_RATIO_OUT};
    endcase
  endfunction : div_out
  // ==========================================================================
  // Sequence
  initial begin
    logic [7:0] m, k;
    repeat (20) @(posedge CLK_IN);
    RST_IN <= 1'b0;
    @(posedge CLK_IN);
    #1;
    chk(PLL_A_ENABLE_OUT & PLL_A_CAL_RUN_OUT, 1, "auto cal");
    cal_wait(CAL_CYCLES);
    rdc(ba(IDX_A_CTRL0), 32'h1e, RESP_OKAY);
    chk(PLL_A_POST_RATIO_OUT, 8, "post reset");
    // Reserved bits written as ones must read back as zero
    for (int i = 0; i < 4; i++) begin
      m = i[0] ? 8'h1f : 8'h07;
      rdc(ba(IDX_A_REF_DIV + 8'(i)), 0, RESP_OKAY);
      for (int c = 0; c < 3; c++) begin
        k = (c == 2) ? m : 8'(c);
        wr(ba(IDX_A_REF_DIV + 8'(i)), {24'hffffff, k | ~m}, 4'hf, RESP_OKAY);
        rdc(ba(IDX_A_REF_DIV + 8'(i)), k, RESP_OKAY);
        chk(div_out(i), (k == 0) ? 7'h41 : 7'(k + 1), "divider");
      end
    end
    for (int c = 0; c < 8; c++) begin
      wr(ba(IDX_A_CTRL0), 32'(c * 4 + 2), 4'hf, RESP_OKAY);
      @(posedge CLK_IN);
      chk(PLL_A_POST_RATIO_OUT, (c < 2) ? 2 : c + 1, "post");
    end
    for (int e = 1; e >= 0; e--) begin
      wr(ba(IDX_A_CTRL0), 32'h1c | 32'(e * 2), 4'hf, RESP_OKAY);
      RESYNC_EVENT_IN <= 1'b1;
      @(posedge CLK_IN);
      RESYNC_EVENT_IN <= 1'b0;
      #1 chk(PLL_A_RESYNC_OUT, e, "resync");
      @(posedge CLK_IN);
      #1 chk(PLL_A_RESYNC_OUT, 0, "resync end");
    end
    wr(ba(IDX_A_CTRL0), 32'h1d, 4'hf, RESP_OKAY);
    @(posedge CLK_IN);
    #1 chk({PLL_A_ENABLE_OUT, PLL_A_CAL_RESET_OUT, PLL_A_CAL_DONE_OUT}, 3'b010, "pdn");
    wr(ba(IDX_A_CTRL0), 32'h1c, 4'h1, RESP_OKAY);
    #1 chk({PLL_A_ENABLE_OUT, PLL_A_CAL_RUN_OUT}, 2'b11, "restart");
    cal_wait(CAL_CYCLES - 1);
    // Zero strobe must leave the register alone
    wr(ba(IDX_A_CTRL0), 32'h1d, 4'h0, RESP_OKAY);
    rdc(ba(IDX_A_CTRL0), 32'h1c, RESP_OKAY);
    wr(12'h100, 32'h5, 4'hf, RESP_SLVERR);
    rdc(12'h100, 0, RESP_SLVERR);
    wr(ba(IDX_STATUS), 0, 4'hf, RESP_OKAY);
    rdc(ba(IDX_STATUS), 3, RESP_OKAY);
    // Second reset with power-down set restores auto calibration
    wr(ba(IDX_A_CTRL0), 32'h1d, 4'hf, RESP_OKAY);
    RST_IN <= 1'b1;
    repeat (2) @(posedge CLK_IN);
    RST_IN <= 1'b0;
    @(posedge CLK_IN);
    #1 chk(PLL_A_ENABLE_OUT & PLL_A_CAL_RUN_OUT, 1, "reset cal");
    rdc(ba(IDX_A_CTRL0), 32'h1e, RESP_OKAY);
    end_of_test();
  end
endmodule : pll_divider_config_regs_bench
